// ---- common/tw_defines.svh ----
// Shared constants of the three-wire serial memory command port
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// Opcode field, the two bits that follow the start bit
`define TW_OP_EXT        2'h0
`define TW_OP_WRITE      2'h1
`define TW_OP_READ       2'h2
`define TW_OP_ERASE      2'h3

// Sub-code of the extended opcode, the two top address bits
`define TW_SUB_LOCK      2'h0
`define TW_SUB_PROG_ALL  2'h1
`define TW_SUB_CLEAR_ALL 2'h2
`define TW_SUB_UNLOCK    2'h3

// Frame layout, in clocks after the start bit
`define TW_OP_BITS       2
`define TW_HEAD_BITS     4
`define TW_WORD_BITS     16

// Content of an erased or never written word
`define TW_ERASED        16'hffff

// Default address width, smallest capacity (64 words)
`define TW_ADDR_BITS     6

// Programming time, in microseconds, and the system clock rate
`define TW_PROG_TYP_US   4000
`define TW_PROG_MAX_US   8000
`define TW_CLK_MHZ       125

`endif

// ---- common/tw_pkg.sv ----
// Types shared by the three-wire serial memory command port
package tw_pkg;

  // Nonvolatile engine state
  typedef enum logic [0:0] {
    TW_IDLE = 1'b0,
    TW_PROG = 1'b1
  } tw_state_e;

endpackage

// ---- hw/tw_sync.sv ----
`timescale 1ns/1ns
// Two-stage level synchroniser, one per bit of a bundle
module tw_sync #(
  parameter int W = 1
) (
  // Destination clock and its reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Level from the other domain, and its synchronised copy
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // Both stages; only the second one is read outside
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tw_sync_s;

  tw_sync_s q;  // Registered stages
  tw_sync_s d;  // Next value

  if (W < 1) begin : g_bad_width
    $error("tw_sync: W must be at least 1");
  end

  // The first stage feeds the second and nothing else
  always_comb begin
    d.s1 = i_d;
    d.s2 = q.s1;
    if (!i_resetn) begin
      d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_q = q.s2;

endmodule

// ---- hw/tw_array.sv ----
`timescale 1ns/1ns
// Word array of the serial memory, 16-bit words
`include "tw_defines.svh"
module tw_array #(
  parameter int AW = `TW_ADDR_BITS
) (
  // Write side, on the system clock
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [15:0]   i_wdata,
  // Read side, unclocked
  input  wire logic [AW-1:0] i_raddr,
  output logic      [15:0]   o_rdata
);

  localparam int WORDS = 1 << AW;  // Capacity in words

  logic [15:0] mem [0:WORDS-1];    // Cell contents

  // Delivered content: every word erased
  initial begin
    for (int i = 0; i < WORDS; i++) begin
      mem[i] = `TW_ERASED;
    end
  end

  // Writes only happen during a programming cycle
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read by the serial-clock side; safe because the content never
  // changes while that side is allowed to clock a read
  assign o_rdata = mem[i_raddr];

endmodule

// ---- hw/tw_command_port.sv ----
`timescale 1ns/1ns
// Serial command front end of a 16-bit word nonvolatile memory
`include "tw_defines.svh"

// How it works
// - Bits sampled on serial clock rise, chip selected
// - Select low: clock and input ignored
// - First high input after select is start
// - Low input before start is padding
// - Read: dummy low after last address bit
// - Then sixteen data bits, one per rise
// - More clocks read the next word
// - Read address wraps from top to zero
// - Programming starts on select fall, exact count
// - Clock ignored while programming runs
// - Programming needs the unlocked mode
// - Programming cycle takes the fixed cycle time
// - Select high while programming shows busy/ready
// - Array starts with every word erased
// - Lock/unlock take effect on select fall
// - Wrong clock count cancels programming
// - Reset or low supply locks, cancels pending
// - Start bit during ready releases output
module tw_command_port
  import tw_pkg::*;
#(
  parameter int ADDR_BITS   = `TW_ADDR_BITS,
  parameter int PROG_CYCLES = `TW_PROG_TYP_US * `TW_CLK_MHZ
) (
  // System clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Supply monitor, high while the supply is too low to program
  input  wire logic i_supply_low,
  // Serial link from the host
  input  wire logic i_serial_clock,
  input  wire logic i_chip_select,
  input  wire logic i_serial_in,
  // Serial data output, three-state
  output logic      o_serial_out,
  output logic      o_serial_out_en,
  // Status
  output logic      o_busy,
  output logic      o_unlocked
);

  localparam int AW     = ADDR_BITS;                  // Address width
  localparam int WORDS  = 1 << AW;                    // Capacity
  localparam int L      = `TW_OP_BITS + AW;           // Short frame
  localparam int LW     = L + `TW_WORD_BITS;          // Frame with data
  localparam int TW     = $clog2(PROG_CYCLES + 1);    // Timer width
  localparam int MAXCYC = `TW_PROG_MAX_US * `TW_CLK_MHZ;

  // Refuse shapes the logic cannot serve
  if (AW < 6 || AW > 8) begin : g_bad_addr
    $error("tw_command_port: ADDR_BITS must be 6 to 8");
  end
  if (PROG_CYCLES <= WORDS || PROG_CYCLES > MAXCYC) begin : g_bad_prog
    $error("tw_command_port: PROG_CYCLES out of range");
  end

  // Link-side state, clocked by the serial clock
  typedef struct packed {
    logic          ep;     // Frame tag this state belongs to
    logic          start;  // Start bit taken in this frame
    logic [5:0]    cnt;    // Clocks after the start bit, saturating
    logic [3:0]    head;   // Opcode and two top address bits
    logic [AW-1:0] addr;   // Address, then read pointer
    logic [15:0]   data;   // Write data
    logic          rd;     // Read output running
    logic          dout;   // Bit being presented
    logic [3:0]    left;   // Bits left in the word, 0 means reload
    logic [14:0]   sh;     // Rest of the word being sent
  } tw_link_s;

  // System-side state
  typedef struct packed {
    tw_state_e     st;       // Engine state
    logic          busy;     // Programming cycle running
    logic          ep;       // Frame tag, flips on every deselect
    logic          unlocked; // Programming allowed
    logic          status;   // Busy/ready shown on reselect
    logic          all;      // Whole-array operation
    logic [AW-1:0] waddr;    // Target word
    logic [15:0]   wdata;    // Value to program
    logic [TW-1:0] tmr;      // Cycle timer
    logic          cs;       // Previous synchronised select
    logic          dout;     // Output data flop
    logic          doen;     // Output enable flop
  } tw_ctl_s;

  tw_link_s      lk_q;       // Link registers
  tw_link_s      lk_d;       // Link next value
  tw_link_s      cur;        // Link state after a new-frame clear
  tw_ctl_s       ctl_q;      // System registers
  tw_ctl_s       ctl_d;      // System next value
  logic [1:0]    pin_s;      // Select and supply monitor, synced
  logic [3:0]    lk_s;       // Link flags, synced to system clock
  logic [1:0]    sys_s;      // Reset and busy, synced to serial clock
  logic          cs_s;       // Chip select, system domain
  logic          low_s;      // Supply low, system domain
  logic          rst_lk_n;   // Reset seen by the link side
  logic          busy_lk;    // Busy seen by the link side
  logic          frame_new;  // First rise of a new frame
  logic          cs_fall;    // Deselect seen by the system side
  logic          mine;       // Synced link flags are of this frame
  logic          go;         // Programming instruction accepted
  logic          all_op;     // Accepted instruction spans the array
  logic [15:0]   val;        // Accepted value
  logic [15:0]   rdata;      // Word at the read pointer
  logic          mem_we;     // Array write strobe
  logic [AW-1:0] mem_waddr;  // Array write address
  logic          lk_off;     // Link checks off while either reset stands

  // Pins into the system domain
  tw_sync #(.W(2)) u_pin_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_chip_select, i_supply_low}),
    .o_q      (pin_s)
  );

  // Link flags into the system domain: tag, start, read, bit
  tw_sync #(.W(4)) u_lk_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({lk_q.ep, lk_q.start, lk_q.rd, lk_q.dout}),
    .o_q      (lk_s)
  );

  // Reset and busy into the link domain; this pair must run before
  // reset is known there, so its own reset is held inactive
  tw_sync #(.W(2)) u_sys_sync (
    .i_clk    (i_serial_clock),
    .i_resetn (1'b1),
    .i_d      ({i_resetn, ctl_q.busy}),
    .o_q      (sys_s)
  );

  // Word array
  tw_array #(.AW(AW)) u_array (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (ctl_q.wdata),
    .i_raddr (lk_q.addr),
    .o_rdata (rdata)
  );

  assign cs_s     = pin_s[1];
  assign low_s    = pin_s[0];
  assign rst_lk_n = sys_s[1];
  assign busy_lk  = sys_s[0];
  // The link synchroniser holds no known value until serial clocks arrive
  assign lk_off   = !rst_lk_n || !i_resetn;
  assign cs_fall  = ctl_q.cs && !cs_s;
  assign mine     = lk_s[3] == ctl_q.ep;

  // The system tag only changes while select is low, long before the
  // next frame's first rise, so the link side reads it as a static level
  assign frame_new = ctl_q.ep != lk_q.ep;

  // Link side: start detection, shifting and read output
  always_comb begin
    cur  = lk_q;
    lk_d = lk_q;
    if (frame_new) begin
      cur.ep    = ctl_q.ep;
      cur.start = 1'b0;
      cur.cnt   = '0;
      cur.rd    = 1'b0;
    end
    if (!rst_lk_n) begin
      lk_d = '0;
    end else if (i_chip_select) begin
      lk_d = cur;
      if (!cur.start) begin
        // Padding while low, start once high; locked out while busy
        lk_d.start = i_serial_in && !busy_lk;
      end else begin
        if (cur.cnt != 6'h3f) begin
          lk_d.cnt = cur.cnt + 6'h01;
        end
        if (cur.cnt < 6'(`TW_HEAD_BITS)) begin
          lk_d.head = {cur.head[2:0], i_serial_in};
        end
        if (cur.cnt >= 6'(`TW_OP_BITS) && cur.cnt < 6'(L)) begin
          lk_d.addr = {cur.addr[AW-2:0], i_serial_in};
        end
        if (cur.cnt >= 6'(L) && cur.cnt < 6'(LW)) begin
          lk_d.data = {cur.data[14:0], i_serial_in};
        end
        if (cur.rd) begin
          if (cur.left == 4'h0) begin
            // Next word, most significant bit first
            lk_d.dout = rdata[15];
            lk_d.sh   = rdata[14:0];
            lk_d.left = 4'hf;
            lk_d.addr = AW'(cur.addr + 1'b1);
          end else begin
            lk_d.dout = cur.sh[14];
            lk_d.sh   = {cur.sh[13:0], 1'b0};
            lk_d.left = cur.left - 4'h1;
          end
        end else if (cur.cnt == 6'(L - 1) &&
                     cur.head[3:2] == `TW_OP_READ) begin
          // Last address bit arrives now: present the dummy low bit
          lk_d.rd   = 1'b1;
          lk_d.dout = 1'b0;
          lk_d.left = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge i_serial_clock) begin
    lk_q <= lk_d;
  end

  // Array write: one word, or one word per cycle across the array
  assign mem_we    = ctl_q.busy && (ctl_q.all ? ctl_q.tmr < TW'(WORDS)
                                              : ctl_q.tmr == '0);
  assign mem_waddr = ctl_q.all ? ctl_q.tmr[AW-1:0] : ctl_q.waddr;

  // System side: decode at deselect, timing, and the output pin
  always_comb begin
    go     = 1'b0;
    all_op = 1'b0;
    val    = `TW_ERASED;
    ctl_d  = ctl_q;
    ctl_d.cs = cs_s;
    if (ctl_q.st == TW_PROG) begin
      ctl_d.tmr = TW'(ctl_q.tmr + 1'b1);
      if (ctl_q.tmr == TW'(PROG_CYCLES - 1)) begin
        ctl_d.st = TW_IDLE;
      end
    end else if (cs_fall && lk_q.start && lk_q.ep == ctl_q.ep && !low_s) begin
      // Link fields are static once select is low; programming needs the exact count
      case (lk_q.head[3:2])
        `TW_OP_WRITE: begin
          go  = lk_q.cnt == 6'(LW);
          val = lk_q.data;
        end
        `TW_OP_ERASE: begin
          go = lk_q.cnt == 6'(L);
        end
        `TW_OP_READ: begin
          go = 1'b0;
        end
        default: begin
          case (lk_q.head[1:0])
            `TW_SUB_PROG_ALL: begin
              go     = lk_q.cnt == 6'(LW);
              all_op = 1'b1;
              val    = lk_q.data;
            end
            `TW_SUB_CLEAR_ALL: begin
              go     = lk_q.cnt == 6'(L);
              all_op = 1'b1;
            end
            `TW_SUB_UNLOCK: begin
              if (lk_q.cnt >= 6'(`TW_HEAD_BITS)) begin
                ctl_d.unlocked = 1'b1;
              end
            end
            default: begin
              if (lk_q.cnt >= 6'(`TW_HEAD_BITS)) begin
                ctl_d.unlocked = 1'b0;
              end
            end
          endcase
        end
      endcase
      if (go && ctl_q.unlocked) begin
        ctl_d.st     = TW_PROG;
        ctl_d.tmr    = '0;
        ctl_d.status = 1'b1;
        ctl_d.all    = all_op;
        ctl_d.waddr  = lk_q.addr;
        ctl_d.wdata  = val;
      end
    end
    if (cs_fall) begin
      ctl_d.ep = ~ctl_q.ep;
    end
    // Low supply wins over any unlock decoded in the same cycle
    if (low_s) begin
      ctl_d.unlocked = 1'b0;
    end
    // A new start bit ends the busy/ready display; the link sees busy two
    // rises late, so a start taken during a cycle is not honoured here
    if (cs_s && lk_s[2] && mine && !ctl_q.busy) begin
      ctl_d.status = 1'b0;
    end
    ctl_d.busy = ctl_d.st == TW_PROG;
    // Output pin; the crossing adds about three system clocks of delay,
    // far inside the allowed output delay of the slowest link
    ctl_d.dout = 1'b0;
    ctl_d.doen = 1'b0;
    if (!cs_s) begin
      ctl_d.doen = 1'b0;
    end else if (lk_s[1] && mine && !ctl_q.busy) begin
      ctl_d.doen = 1'b1;
      ctl_d.dout = lk_s[0];
    end else if (ctl_q.status && !(lk_s[2] && mine && !ctl_q.busy)) begin
      ctl_d.doen = 1'b1;
      ctl_d.dout = !ctl_q.busy;
    end
    if (!i_resetn) begin
      ctl_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    ctl_q <= ctl_d;
  end

  assign o_serial_out    = ctl_q.dout;
  assign o_serial_out_en = ctl_q.doen;
  assign o_busy          = ctl_q.busy;
  assign o_unlocked      = ctl_q.unlocked;

  // System-side checks
  a_standby_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !cs_s |=> !o_serial_out_en) else $error("output driven while deselected");
  a_prog_length: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(ctl_q.busy) |-> $past(ctl_q.tmr) == TW'(PROG_CYCLES - 1))
    else $error("programming cycle length wrong");
  a_prog_unlocked: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(ctl_q.busy) |-> $past(ctl_q.unlocked)) else $error("programmed while locked");
  a_prog_on_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(ctl_q.busy) |-> $past(cs_fall)) else $error("programming began without deselect");
  a_exact_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(ctl_q.busy) |-> $past(lk_q.cnt == 6'(L) || lk_q.cnt == 6'(LW)))
    else $error("programming began on a wrong clock count");
  a_busy_shows_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ctl_q.busy && ctl_q.status && cs_s ##1 o_serial_out_en |-> !o_serial_out)
    else $error("busy not shown low");
  a_supply_locks: assert property (@(posedge i_clk) disable iff (!i_resetn)
    low_s |=> !ctl_q.unlocked) else $error("unlocked during low supply");

  // Link-side checks
  a_standby_hold: assert property (@(posedge i_serial_clock) disable iff (lk_off)
    !i_chip_select |=> $stable(lk_q)) else $error("link state moved while deselected");
  a_padding_ignored: assert property (@(posedge i_serial_clock) disable iff (lk_off)
    i_chip_select && !frame_new && !lk_q.start && !i_serial_in |=> !lk_q.start)
    else $error("padding clock taken as start");
  a_dummy_low: assert property (@(posedge i_serial_clock) disable iff (lk_off)
    $rose(lk_q.rd) |-> !lk_q.dout && lk_q.left == 4'h0) else $error("dummy bit not low");
  a_next_word: assert property (@(posedge i_serial_clock) disable iff (lk_off)
    i_chip_select && !frame_new && lk_q.rd && lk_q.left == 4'h0
      |=> lk_q.addr == AW'($past(lk_q.addr) + 1'b1) && lk_q.left == 4'hf)
    else $error("read pointer did not advance or wrap");

  // Main scenarios
  c_program: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(ctl_q.busy));
  c_ready: cover property (@(posedge i_clk) disable iff (!i_resetn)
    o_serial_out_en && o_serial_out && ctl_q.status);
  c_wrap: cover property (@(posedge i_serial_clock) disable iff (lk_off)
    lk_q.rd && lk_q.left == 4'h0 && lk_q.addr == '1);

endmodule

// ---- testbench/tw_host_model.sv ----
`timescale 1ns/1ns
// Host controller model that drives the serial link of the command port
`include "tw_defines.svh"
module tw_host_model #(
  parameter int AW = `TW_ADDR_BITS
) (
  // Serial link towards the device
  output logic      o_serial_clock,
  output logic      o_chip_select,
  output logic      o_serial_in,
  // Serial data back from the device
  input  wire logic i_serial_out,
  input  wire logic i_serial_out_en
);
  logic        tx_bits[$]; // Bits of the next frame, first bit sent first
  logic [15:0] rx_word;    // Last word shifted in
  logic        dummy_ok;   // Dummy bit seen driven low
  event        word_ev;    // Fires once per received word

  // Link clock starts low and runs outside frames only in idle
  initial begin
    o_serial_clock = 1'b0;
    o_chip_select  = 1'b0;
    o_serial_in    = 1'b0;
  end

  // One link clock period; odd offsets keep edges off the system clock
  task automatic clk_bit(input logic b);
    o_serial_in = b;
    #41 o_serial_clock = 1'b1;
    #80 o_serial_clock = 1'b0;
    #39;
  endtask

  // Frame builders, most significant bit first
  task automatic put_bit(input logic b);
    tx_bits.push_back(b);
  endtask
  task automatic put_op(input logic [1:0] v);
    for (int i = 1; i >= 0; i--) tx_bits.push_back(v[i]);
  endtask
  task automatic put_addr(input logic [AW-1:0] v);
    for (int i = AW - 1; i >= 0; i--) tx_bits.push_back(v[i]);
  endtask
  task automatic put_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) tx_bits.push_back(v[i]);
  endtask

  // Clocks while deselected with the input high; they must do nothing
  task automatic idle(input int n);
    repeat (n) clk_bit(1'b1);
  endtask

  // Send the built frame, then read words; a bit is taken just before the next rise
  task automatic run(input int nread);
    o_chip_select = 1'b1;
    #200;
    while (tx_bits.size() > 0) clk_bit(tx_bits.pop_front());
    dummy_ok = i_serial_out_en & ~i_serial_out;
    repeat (nread) begin
      for (int i = 15; i >= 0; i--) begin
        clk_bit(1'b0);
        rx_word[i] = i_serial_out_en ? i_serial_out : 1'bx;
      end
      -> word_ev;
    end
    o_chip_select = 1'b0;
    #240;
  endtask

  // Status check with select held high and the input low, then a start bit
  task automatic poll(output logic busy_low, output logic ready, output logic released);
    int n;
    o_serial_in   = 1'b0;
    o_chip_select = 1'b1;
    #80 busy_low = i_serial_out_en & ~i_serial_out;
    n = 0;
    while (!(i_serial_out_en === 1'b1 && i_serial_out === 1'b1) && n < 600) begin
      #8 n++;
    end
    ready = i_serial_out_en & i_serial_out;
    clk_bit(1'b1);
    released = ~i_serial_out_en;
    o_chip_select = 1'b0;
    #240;
  endtask
endmodule

// ---- testbench/tw_command_port_tb_top.sv ----
`timescale 1ns/1ns
// Self-checking testbench of the serial memory command port
`include "tw_defines.svh"
module tw_command_port_tb_top;
  localparam int AW   = 6;   // Smallest capacity
  localparam int PROG = 300; // Short programming time for simulation

  logic        i_clk;          // System clock, 8 ns
  logic        i_resetn;       // Synchronous reset, active low
  logic        i_supply_low;   // Supply monitor
  logic        serial_clock;   // Link lines from the host model
  logic        chip_select;
  logic        serial_in;
  logic        serial_out;     // Device answer
  logic        serial_out_en;
  logic        busy;
  logic        unlocked;
  logic [15:0] exp_q[$];       // Expected words, oldest first
  logic [15:0] d;              // Random data word
  int          num_errors = 0;
  int          n_checks = 0;
  int          busy_len = 0;
  int          seed = 25;

  tw_command_port #(
    .ADDR_BITS   (AW),
    .PROG_CYCLES (PROG)
  ) tw_command_port_i (
    .i_clk           (i_clk),
    .i_resetn        (i_resetn),
    .i_supply_low    (i_supply_low),
    .i_serial_clock  (serial_clock),
    .i_chip_select   (chip_select),
    .i_serial_in     (serial_in),
    .o_serial_out    (serial_out),
    .o_serial_out_en (serial_out_en),
    .o_busy          (busy),
    .o_unlocked      (unlocked)
  );
  tw_host_model #(
    .AW (AW)
  ) tw_host_model_i (
    .o_serial_clock  (serial_clock),
    .o_chip_select   (chip_select),
    .o_serial_in     (serial_in),
    .i_serial_out    (serial_out),
    .i_serial_out_en (serial_out_en)
  );

  // System clock
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk({15'h0, got}, {15'h0, exp}, what);
  endtask
  task automatic test_end(input string name);
    $display("test %s ended, mismatches so far %0d", name, num_errors);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Address of an extended instruction: sub-code on top, rest zero
  function automatic logic [AW-1:0] ea(input logic [1:0] sub);
    return {sub, {(AW - 2){1'b0}}};
  endfunction

  // Word monitor: each received word is matched to the oldest note
  always @(tw_host_model_i.word_ev) begin
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("mismatch at %0t: word with no expectation", $time);
    end else begin
      chk(tw_host_model_i.rx_word, exp_q.pop_front(), "read word");
    end
  end

  // Length of each busy period in system clocks, sampled away from the launching edge
  always @(negedge i_clk) begin
    if (busy === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      n_checks++;
      if (busy_len < PROG || busy_len > PROG + 2) begin
        num_errors++;
        $display("mismatch at %0t: busy lasted %0d clocks", $time, busy_len);
      end
      busy_len = 0;
    end
  end

  // Read two words in a row from an address
  task automatic rd(input logic [AW-1:0] a, input logic [15:0] w0, input logic [15:0] w1);
    tw_host_model_i.put_bit(1'b1);
    tw_host_model_i.put_op(`TW_OP_READ);
    tw_host_model_i.put_addr(a);
    exp_q.push_back(w0);
    exp_q.push_back(w1);
    tw_host_model_i.run(2);
    chk_bit(tw_host_model_i.dummy_ok, 1'b1, "dummy bit");
  endtask

  // Lock or unlock, behind padding clocks
  task automatic ext(input logic [1:0] sub, input logic exp_unl);
    repeat (7) tw_host_model_i.put_bit(1'b0);
    tw_host_model_i.put_bit(1'b1);
    tw_host_model_i.put_op(`TW_OP_EXT);
    tw_host_model_i.put_addr(ea(sub));
    tw_host_model_i.run(0);
    chk_bit(unlocked, exp_unl, "enable mode");
  endtask

  // Programming frame; extra adds clocks, or below zero removes one; then poll when started
  task automatic prog(input logic [1:0] op, input logic [AW-1:0] a, input logic [15:0] w,
                      input int extra, input logic exp_busy);
    logic bl;
    logic rdy;
    logic rel;
    tw_host_model_i.put_bit(1'b1);
    tw_host_model_i.put_op(op);
    tw_host_model_i.put_addr(a);
    if (op == `TW_OP_WRITE || (op == `TW_OP_EXT && a == ea(`TW_SUB_PROG_ALL))) begin
      tw_host_model_i.put_word(w);
    end
    repeat (extra) tw_host_model_i.put_bit(1'b0);
    if (extra < 0) void'(tw_host_model_i.tx_bits.pop_back());
    tw_host_model_i.run(0);
    chk_bit(busy, exp_busy, "busy after deselect");
    if (exp_busy) begin
      tw_host_model_i.poll(bl, rdy, rel);
      chk_bit(bl, 1'b1, "busy shown low");
      chk_bit(rdy, 1'b1, "ready shown high");
      chk_bit(rel, 1'b1, "released after start bit");
    end
  endtask

  // Main sequence
  initial begin
    i_resetn     = 1'b0;
    i_supply_low = 1'b0;
    tw_host_model_i.idle(8);
    @(posedge i_clk) #1 i_resetn = 1'b1;
    @(posedge i_clk) #1;
    chk_bit(serial_out_en, 1'b0, "output released");
    chk_bit(unlocked, 1'b0, "locked at reset");
    chk_bit(busy, 1'b0, "idle at reset");
    // The link side leaves reset only after two serial rises of its own
    tw_host_model_i.idle(3);
    test_end("reset");
    rd(ea(2'h0), `TW_ERASED, `TW_ERASED);
    test_end("erased read");
    d = 16'($random(seed));
    prog(`TW_OP_WRITE, {AW{1'b1}}, d, 0, 1'b0);
    ext(`TW_SUB_UNLOCK, 1'b1);
    prog(`TW_OP_WRITE, {AW{1'b1}}, d, 1, 1'b0);
    prog(`TW_OP_WRITE, {AW{1'b1}}, d, -1, 1'b0);
    prog(`TW_OP_WRITE, {AW{1'b1}}, d, 0, 1'b1);
    rd({AW{1'b1}}, d, `TW_ERASED);
    test_end("word write");
    prog(`TW_OP_ERASE, {AW{1'b1}}, d, 0, 1'b1);
    rd({AW{1'b1}}, `TW_ERASED, `TW_ERASED);
    d = 16'($random(seed));
    prog(`TW_OP_EXT, ea(`TW_SUB_PROG_ALL), d, 0, 1'b1);
    rd(6'h15, d, d);
    prog(`TW_OP_EXT, ea(`TW_SUB_CLEAR_ALL), d, 0, 1'b1);
    rd(6'h2a, `TW_ERASED, `TW_ERASED);
    test_end("erase and whole array");
    ext(`TW_SUB_LOCK, 1'b0);
    prog(`TW_OP_ERASE, ea(2'h0), d, 0, 1'b0);
    ext(`TW_SUB_UNLOCK, 1'b1);
    @(posedge i_clk) #1 i_supply_low = 1'b1;
    repeat (10) @(posedge i_clk);
    chk_bit(unlocked, 1'b0, "locked on low supply");
    prog(`TW_OP_ERASE, ea(2'h0), d, 0, 1'b0);
    @(posedge i_clk) #1 i_supply_low = 1'b0;
    test_end("lock and supply");
    test_done();
  end

  // Watchdog
  initial begin
    #400000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
